// ### sim/beat_mem_model.sv
// memory side model: answers each outstanding beat after a settable delay
// assumes a registered level beat request from the block, one beat at a time
`timescale 1ns/1ps
`default_nettype none
module beat_mem_model #(
    parameter logic [31:0] DATA = 32'h1234_5678
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    input  wire logic        beat_req_i,
    input  wire logic [7:0]  delay_i,
    output logic             beat_done_o,
    output logic [31:0]      beat_data_o
);
    logic [7:0] wait_reg;
    logic [7:0] tick_reg;
    always_ff @(posedge clk_sys_i) begin
        tick_reg <= tick_reg + 8'h01;
        if (!rst_b_i) begin
            beat_done_o <= 1'b0;
            wait_reg    <= 8'h00;
            tick_reg    <= 8'h00;
        end else if (beat_done_o) begin
            beat_done_o <= 1'b0; // single pulse, one beat in flight
            wait_reg    <= 8'h00;
        end else if (beat_req_i) begin
            // a slow answer lets an abort land inside a beat
            if (wait_reg >= delay_i) begin
                beat_done_o <= 1'b1;
            end else begin
                wait_reg <= wait_reg + 8'h01;
            end
        end
    end
    // data only holds with done; a moving pattern elsewhere so stale reads show
    assign beat_data_o = beat_done_o ? DATA : ~DATA ^ {4{tick_reg}};
endmodule : beat_mem_model
`default_nettype wire

// ### sim/dma_addr_step_abort_crc_tb.sv
// self-checking bench: address stepping, aborts and checksum
// assumes the memory model answers beats; registers over avalon-mm
`timescale 1ns/1ps
`default_nettype none
module dma_addr_step_abort_crc_tb import dma_step_pkg::*;;
    localparam logic [31:0] MEM_DATA = 32'h1234_5678;
    logic        clk_sys_i, rst_b_i, avs_read_i, avs_write_i, waitreq;
    logic        beat_done, beat_req, block_done;
    logic [7:0]  avs_address_i, mem_delay;
    logic [31:0] avs_writedata_i, readdata, beat_data, src_addr, dst_addr, rdat, crc;
    logic [1:0]  active_ch;
    int          failures, n_tests;

    dma_addr_step_abort_crc dma_addr_step_abort_crc_i (.clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hf), .avs_readdata_o(readdata), .avs_waitrequest_o(waitreq),
        .beat_done_i(beat_done), .beat_data_i(beat_data), .beat_req_o(beat_req),
        .src_addr_o(src_addr), .dst_addr_o(dst_addr), .active_ch_o(active_ch),
        .block_done_o(block_done));
    beat_mem_model #(.DATA(MEM_DATA)) beat_mem_model_i (.clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i), .beat_req_i(beat_req), .delay_i(mem_delay),
        .beat_done_o(beat_done), .beat_data_o(beat_data));

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    task conclude();
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // holds the request until waitrequest is sampled low
    task bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        int n;
        @(posedge clk_sys_i);
        avs_address_i   <= a;
        avs_write_i     <= w;
        avs_read_i      <= !w;
        avs_writedata_i <= wd;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        // a slave that never answers counts as a mismatch
        chk({31'h0, waitreq}, 32'h0);
        rdat = readdata;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        bus(a, 1'b0, 32'h0);
        chk(rdat & m, exp);
    endtask : rd_chk

    function automatic logic [7:0] chan(input logic [1:0] ch, input logic [7:0] off);
        return OFF_CH_BASE + CH_STRIDE * {6'h0, ch} + off;
    endfunction : chan

    function automatic logic [31:0] crc_byte(logic [31:0] c, logic [7:0] d, logic w);
        logic fb;
        for (int k = 7; k >= 0; k--) begin
            fb = (w ? c[31] : c[15]) ^ d[k];
            c = w ? {c[30:0], 1'b0} : {16'h0, c[14:0], 1'b0};
            if (fb) c = c ^ (w ? CRC32_POLY : CRC16_POLY);
        end
        return c;
    endfunction : crc_byte

    task wait_req(input logic v);
        int n;
        n = 0;
        while (beat_req !== v && n < 200) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk(beat_req, v);
    endtask : wait_req

    task start(input logic [1:0] ch, input block_xfer_ctrl_t c, input logic [31:0] s,
               input logic [31:0] d, input logic [31:0] cnt);
        bus(chan(ch, CH_SRC), 1'b1, s);
        bus(chan(ch, CH_DST), 1'b1, d);
        bus(chan(ch, CH_CNT), 1'b1, cnt);
        bus(chan(ch, CH_XFER_CTRL), 1'b1, {23'h0, 1'b1, c});
    endtask : start

    task xfer(input logic [1:0] ch, input block_xfer_ctrl_t c, input logic [31:0] s,
              input logic [31:0] d, input int cnt);
        logic [31:0] ss, ds;
        int n;
        ss = c.src_incr_en ? (32'h1 << c.beat_bytes) : 32'h0;
        ss = c.step_target_sel ? ss << c.step_power : ss;
        ds = c.dst_incr_en ? (32'h1 << c.beat_bytes) : 32'h0;
        ds = c.step_target_sel ? ds : ds << c.step_power;
        start(ch, c, s, d, 32'(cnt));
        for (int i = 0; i < cnt; i++) begin
            wait_req(1'b1);
            chk(src_addr, s + 32'(i) * ss);
            chk(dst_addr, d + 32'(i) * ds);
            chk({30'h0, active_ch}, {30'h0, ch});
            wait_req(1'b0);
        end
        n = 0;
        while (block_done !== 1'b1 && n < 20) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk(block_done, 1'b1);
        rd_chk(chan(ch, CH_XFER_CTRL), 32'h0, 32'h100);
    endtask : xfer

    // no new beat may start once an abort has landed
    task quiet();
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_sys_i);
            chk(beat_req, 1'b0);
        end
    endtask : quiet

    task t_crc();
        for (int w = 0; w < 2; w++) begin
            bus(OFF_CRC_CFG, 1'b1, {30'h0, 1'b1, w[0]});
            crc = w[0] ? CRC32_SEED : CRC16_SEED;
            for (int b = 0; b < 4; b++) crc = crc_byte(crc, MEM_DATA[8*(b%2)+:8], w[0]);
            xfer(2'h3, 8'h05, 32'h3000, 32'h4000, 2);
            rd_chk(OFF_CRC_VAL, crc,
                   w[0] ? 32'hffff_ffff : 32'h0000_ffff);
            rd_chk(OFF_STATUS, 32'h0003_0002, 32'h0003_ffff);
        end
    endtask : t_crc

    task t_chan_abort();
        mem_delay <= 8'd40;
        start(2'h0, 8'h06, 32'h5000, 32'h6000, 32'h8);
        wait_req(1'b1);
        bus(chan(2'h0, CH_XFER_CTRL), 1'b1, 32'h06);
        rd_chk(chan(2'h0, CH_XFER_CTRL), 32'h100, 32'h100);
        chk(beat_req, 1'b1);
        wait_req(1'b0);
        quiet();
        rd_chk(chan(2'h0, CH_XFER_CTRL), 32'h0, 32'h100);
    endtask : t_chan_abort

    task t_ctrl_abort();
        start(2'h0, 8'h06, 32'h5000, 32'h6000, 32'h8);
        start(2'h1, 8'h06, 32'h7000, 32'h6100, 32'h8);
        wait_req(1'b1);
        bus(OFF_CTRL, 1'b1, 32'h0);
        rd_chk(OFF_CTRL, 32'h1, 32'h1);
        rd_chk(chan({1'b0, ~active_ch[0]}, CH_XFER_CTRL), 32'h0, 32'h100);
        chk(beat_req, 1'b1);
        wait_req(1'b0);
        quiet();
        rd_chk(OFF_CTRL, 32'h0, 32'h1);
        rd_chk(chan(2'h0, CH_XFER_CTRL), 32'h0, 32'h100);
        rd_chk(chan(2'h1, CH_XFER_CTRL), 32'h0, 32'h100);
    endtask : t_ctrl_abort

    initial begin
        #(8 * 20000);
        failures++;
        conclude();
    end

    initial begin
        failures = 0;
        n_tests = 0;
        rst_b_i = 1'b0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_address_i = 8'h00;
        avs_writedata_i = 32'h0;
        mem_delay = 8'h00;
        repeat (2) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        rd_chk(OFF_CTRL, 32'h0, 32'hffff_ffff);
        bus(8'h30, 1'b1, 32'hffff_ffff);
        rd_chk(8'h30, UNMAPPED_DATA, 32'hffff_ffff);
        bus(OFF_CTRL, 1'b1, 32'h1);
        xfer(2'h0, 8'h36, 32'h1000, 32'h8000, 3);
        mem_delay <= 8'd3;
        xfer(2'h1, 8'h4d, 32'h2000, 32'h9000, 4);
        xfer(2'h2, 8'hfc, 32'h2100, 32'h9100, 3);
        t_crc();
        t_chan_abort();
        t_ctrl_abort();
        conclude();
    end
endmodule : dma_addr_step_abort_crc_tb
`default_nettype wire

// ### verilog/dma_addr_step_abort_crc.sv
// address generation, graceful abort and checksum for a multi-channel dma
// assumes the memory side answers each beat with beat_done_i and read data
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dma_addr_step_abort_crc
    import dma_step_pkg::*;
#(
    parameter int CH = NUM_CH
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        beat_done_i,
    input  wire logic [31:0] beat_data_i,
    output logic             beat_req_o,
    output logic [31:0]      src_addr_o,
    output logic [31:0]      dst_addr_o,
    output logic [1:0]       active_ch_o,
    output logic             block_done_o
);
    typedef struct packed {
        logic                    ctrl_on;
        logic                    ctrl_want;
        logic [CH-1:0]           ch_en;
        logic [CH-1:0]           ch_want;
        logic [CH-1:0][7:0]      xctl;
        logic [CH-1:0][31:0]     src_start;
        logic [CH-1:0][31:0]     dst_start;
        logic [CH-1:0][15:0]     cnt_init;
        logic [15:0]             beat_idx;
        logic [1:0]              cur;
        eng_state_t              st;
        logic [1:0]              wb_cnt;
        logic                    crc32;
        logic [31:0]             crc;
        logic                    waitreq;
        logic [31:0]             rdata;
        logic                    beat_req;
        logic [31:0]             src;
        logic [31:0]             dst;
        logic                    done;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // byte offset of one beat, scaled by 2^step when the side is stepped
    function automatic logic [31:0] step_off(input logic [15:0] n,
                                             input logic [1:0] bsz,
                                             input logic [2:0] pw,
                                             input logic stepped);
        logic [31:0] b;
        b = {16'h0000, n} << bsz;
        step_off = stepped ? (b << pw) : b;
    endfunction : step_off

    // one data byte into the running checksum, msb first
    function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                             input logic [7:0] d,
                                             input logic wide);
        logic [31:0] r;
        logic        fb;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            fb = (wide ? r[31] : r[15]) ^ d[i];
            r = {r[30:0], 1'b0};
            if (fb) begin
                r = r ^ (wide ? CRC32_POLY : CRC16_POLY);
            end
            if (!wide) begin
                r[31:16] = 16'h0000;
            end
        end
        crc_byte = r;
    endfunction : crc_byte

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                old[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = old;
    endfunction : merge

    logic [7:0]       ch_off;
    logic [1:0]       ch_sel;
    logic             ch_hit;
    block_xfer_ctrl_t cx;
    logic [31:0]      wv;
    logic [CH-1:0]    pick;

    always_comb begin
        state_next = state_reg;
        state_next.waitreq = 1'b1;
        state_next.beat_req = 1'b0;
        state_next.done = 1'b0;
        ch_off = avs_address_i - OFF_CH_BASE;
        ch_sel = ch_off[5:4];
        ch_hit = (avs_address_i >= OFF_CH_BASE) && (ch_off < 8'(CH) * CH_STRIDE);
        cx = block_xfer_ctrl_t'(state_reg.xctl[state_reg.cur]);
        wv = 32'h0000_0000;
        pick = '0;

        // register access: one wait cycle, answer on the following edge
        if ((avs_read_i || avs_write_i) && state_reg.waitreq) begin
            state_next.waitreq = 1'b0;
            state_next.rdata = UNMAPPED_DATA;
            if (avs_address_i == OFF_CTRL) begin
                wv = merge({31'h0, state_reg.ctrl_want}, avs_writedata_i, avs_byteenable_i);
                if (avs_write_i) begin
                    state_next.ctrl_want = wv[0];
                end
                state_next.rdata = {31'h0, state_reg.ctrl_on};
            end else if (avs_address_i == OFF_STATUS) begin
                state_next.rdata = {14'h0, state_reg.cur, state_reg.beat_idx};
            end else if (avs_address_i == OFF_CRC_CFG) begin
                if (avs_write_i && avs_byteenable_i[0]) begin
                    state_next.crc32 = avs_writedata_i[0];
                    if (avs_writedata_i[1]) begin
                        state_next.crc = avs_writedata_i[0] ? CRC32_SEED : CRC16_SEED;
                    end
                end
                state_next.rdata = {31'h0, state_reg.crc32};
            end else if (avs_address_i == OFF_CRC_VAL) begin
                state_next.rdata = state_reg.crc;
            end else if (ch_hit) begin
                case (ch_off[3:0])
                    CH_XFER_CTRL[3:0]: begin
                        wv = merge({23'h0, state_reg.ch_want[ch_sel], state_reg.xctl[ch_sel]},
                                   avs_writedata_i, avs_byteenable_i);
                        if (avs_write_i) begin
                            state_next.xctl[ch_sel] = wv[7:0];
                            state_next.ch_want[ch_sel] = wv[8];
                        end
                        state_next.rdata = {23'h0, state_reg.ch_en[ch_sel],
                                            state_reg.xctl[ch_sel]};
                    end
                    CH_SRC[3:0]: begin
                        if (avs_write_i) begin
                            state_next.src_start[ch_sel] = merge(
                                state_reg.src_start[ch_sel], avs_writedata_i, avs_byteenable_i);
                        end
                        state_next.rdata = state_reg.src_start[ch_sel];
                    end
                    CH_DST[3:0]: begin
                        if (avs_write_i) begin
                            state_next.dst_start[ch_sel] = merge(
                                state_reg.dst_start[ch_sel], avs_writedata_i, avs_byteenable_i);
                        end
                        state_next.rdata = state_reg.dst_start[ch_sel];
                    end
                    CH_CNT[3:0]: begin
                        wv = merge({16'h0, state_reg.cnt_init[ch_sel]}, avs_writedata_i,
                                   avs_byteenable_i);
                        if (avs_write_i) begin
                            state_next.cnt_init[ch_sel] = wv[15:0];
                        end
                        state_next.rdata = {16'h0, state_reg.cnt_init[ch_sel]};
                    end
                    default: state_next.rdata = UNMAPPED_DATA;
                endcase
            end
        end

        // enabling follows the request at once; disabling waits for the engine only on the channel it is serving
        for (int i = 0; i < CH; i++) begin
            if (state_reg.ch_want[i] && state_reg.ctrl_want && !state_reg.ch_en[i]) begin
                state_next.ch_en[i] = 1'b1;
            end
            if ((!state_reg.ch_want[i] || !state_reg.ctrl_want) && state_reg.ch_en[i]
                && !(state_reg.st != ENG_IDLE && state_reg.cur == 2'(i))) begin
                state_next.ch_en[i] = 1'b0;
                state_next.ch_want[i] = 1'b0;
            end
        end
        if (state_reg.ctrl_want) begin
            state_next.ctrl_on = 1'b1;
        end else if (state_reg.ch_en == '0 && state_reg.st == ENG_IDLE) begin
            state_next.ctrl_on = 1'b0;
        end

        case (state_reg.st)
            ENG_IDLE: begin
                for (int i = CH - 1; i >= 0; i--) begin
                    if (state_reg.ch_en[i] && state_reg.ch_want[i] && state_reg.ctrl_want
                        && state_reg.cnt_init[i] != 16'h0000) begin
                        pick = '0;
                        pick[i] = 1'b1;
                        state_next.cur = 2'(i);
                    end
                end
                if (pick != '0) begin
                    state_next.st = ENG_BEAT;
                    state_next.beat_idx = 16'h0000;
                end
            end
            ENG_BEAT: begin
                state_next.beat_req = 1'b1;
                // source: stepped only when target is 1, else one beat
                state_next.src = state_reg.src_start[state_reg.cur] + (cx.src_incr_en ?
                    step_off(state_reg.beat_idx, cx.beat_bytes, cx.step_power,
                             cx.step_target_sel) : 32'h0000_0000);
                // destination: fixed unless enabled; stepped when target is 0
                state_next.dst = state_reg.dst_start[state_reg.cur] + (cx.dst_incr_en ?
                    step_off(state_reg.beat_idx, cx.beat_bytes, cx.step_power,
                             !cx.step_target_sel) : 32'h0000_0000);
                if (state_reg.beat_req && beat_done_i) begin
                    state_next.beat_req = 1'b0;
                    for (int b = 0; b < 4; b++) begin
                        if (3'(b) <= (3'b001 << cx.beat_bytes) - 3'b001) begin
                            state_next.crc = crc_byte(state_next.crc, beat_data_i[b*8 +: 8],
                                                      state_reg.crc32);
                        end
                    end
                    state_next.beat_idx = state_reg.beat_idx + 16'h0001;
                    state_next.st = ENG_WB;
                    state_next.wb_cnt = WB_CYCLES;
                end
            end
            ENG_WB: begin
                // write-back finishes before an abort may take the channel down
                state_next.wb_cnt = state_reg.wb_cnt - 2'h1;
                if (state_reg.wb_cnt == 2'h1) begin
                    if (state_reg.beat_idx == state_reg.cnt_init[state_reg.cur]) begin
                        state_next.done = 1'b1;
                        state_next.st = ENG_IDLE;
                        state_next.ch_want[state_reg.cur] = 1'b0;
                    end else if (!state_reg.ch_want[state_reg.cur] || !state_reg.ctrl_want) begin
                        state_next.st = ENG_IDLE;
                    end else begin
                        state_next.st = ENG_BEAT;
                    end
                end
            end
            default: state_next.st = ENG_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            state_reg <= '0;
            state_reg.crc <= CRC16_SEED;
            state_reg.st <= ENG_IDLE;
            state_reg.waitreq <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign avs_readdata_o = state_reg.rdata;
    assign avs_waitrequest_o = state_reg.waitreq;
    assign beat_req_o = state_reg.beat_req;
    assign src_addr_o = state_reg.src;
    assign dst_addr_o = state_reg.dst;
    assign active_ch_o = state_reg.cur;
    assign block_done_o = state_reg.done;

    sequence s_wb_exit;
        (state_reg.st == ENG_WB) [*2] ##1 (state_reg.st != ENG_WB);
    endsequence

    property p_fixed_dst;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (state_reg.st == ENG_BEAT && !cx.dst_incr_en)
        |=> (dst_addr_o == $past(state_reg.dst_start[state_reg.cur]));
    endproperty
    a_fixed_dst: assert property (p_fixed_dst) else $error("fixed dest moved");

    property p_src_step;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (state_reg.st == ENG_BEAT && cx.src_incr_en && !cx.step_target_sel)
        |=> (src_addr_o == $past(state_reg.src_start[state_reg.cur])
             + ($past({16'h0, state_reg.beat_idx}) << $past(cx.beat_bytes)));
    endproperty
    a_src_step: assert property (p_src_step) else $error("source step wrong");

    property p_wb_hold;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (state_reg.st == ENG_BEAT && beat_req_o && beat_done_i) |=> s_wb_exit;
    endproperty
    a_wb_hold: assert property (p_wb_hold) else $error("write-back cut short");

    property p_idle_off;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        // only the channel that was mid-transfer may stay on one cycle later
        $fell(state_reg.ctrl_want)
        |=> ((state_reg.ch_en & ~(CH'($past(state_reg.st) != ENG_IDLE)
                                  << $past(state_reg.cur))) == '0);
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("idle channel kept");

    property p_active_kept;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (state_reg.st == ENG_BEAT) |-> state_reg.ch_en[state_reg.cur];
    endproperty
    a_active_kept: assert property (p_active_kept) else $error("channel dropped");

    property p_ctrl_off;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        $fell(state_reg.ctrl_on) |-> ($past(state_reg.ch_en) == '0 && !state_reg.ctrl_want);
    endproperty
    a_ctrl_off: assert property (p_ctrl_off) else $error("controller off early");

    property p_crc16_width;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (!state_reg.crc32 && state_reg.crc[31:16] == 16'h0 && state_reg.st == ENG_BEAT)
        |=> (state_reg.crc[31:16] == 16'h0);
    endproperty
    a_crc16_width: assert property (p_crc16_width) else $error("crc16 overflow");

    property p_crc_step;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (state_reg.st == ENG_WB || state_reg.st == ENG_IDLE) && !avs_write_i |=> $stable(state_reg.crc);
    endproperty
    a_crc_step: assert property (p_crc_step) else $error("checksum moved");

    property p_abort_req;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        ($fell(state_reg.ch_want[0]) && state_reg.st == ENG_IDLE) |-> ##[1:2] !state_reg.ch_en[0];
    endproperty
    a_abort_req: assert property (p_abort_req) else $error("abort ignored");
endmodule : dma_addr_step_abort_crc
`default_nettype wire

// ### verilog/dma_step_pkg.sv
// package for the dma address step, abort and checksum block
// assumes a single 125 MHz system clock and an avalon-mm register master
//
// Behaviour
// - stepped source pointer: start plus count times beat bytes times 2^step.
// - step target 0: source advances one beat size per beat.
// - destination advances only when enabled; target 0 uses beat times 2^step.
// - step target 1: destination advances one beat size per beat.
// - destination increment off: destination stays fixed for the whole block.
// - clearing a channel enable is an abort request for that channel.
// - clearing the controller enable aborts every channel.
// - the active channel finishes its beat and write-back before stopping.
// - idle enabled channels are disabled the cycle after the abort.
// - a channel enable reads zero only once the channel is really off.
// - the controller enable reads zero only once all channels are off.
// - checksum engine offers 16-bit ccitt and 32-bit ethernet polynomials.
package dma_step_pkg;
    localparam int          NUM_CH        = 4;
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_STATUS    = 8'h04;
    localparam logic [7:0]  OFF_CRC_CFG   = 8'h08;
    localparam logic [7:0]  OFF_CRC_VAL   = 8'h0c;
    localparam logic [7:0]  OFF_CH_BASE   = 8'h40;
    localparam logic [7:0]  CH_STRIDE     = 8'h10;
    localparam logic [7:0]  CH_XFER_CTRL  = 8'h00;
    localparam logic [7:0]  CH_SRC        = 8'h04;
    localparam logic [7:0]  CH_DST        = 8'h08;
    localparam logic [7:0]  CH_CNT        = 8'h0c;
    localparam logic [31:0] CRC16_POLY    = 32'h0000_1021;
    localparam logic [31:0] CRC32_POLY    = 32'h04c1_1db7;
    localparam logic [31:0] CRC16_SEED    = 32'h0000_ffff;
    localparam logic [31:0] CRC32_SEED    = 32'hffff_ffff;
    localparam logic [1:0]  WB_CYCLES     = 2'h2;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // block_xfer_ctrl layout: [1:0] beat_bytes code, [2] src_incr_en,
    // [3] dst_incr_en, [4] step_target_sel, [7:5] step_power
    typedef struct packed {
        logic [2:0] step_power;
        logic       step_target_sel;
        logic       dst_incr_en;
        logic       src_incr_en;
        logic [1:0] beat_bytes;
    } block_xfer_ctrl_t;

    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } avl_req_t;

    typedef enum logic [1:0] {ENG_IDLE, ENG_BEAT, ENG_WB} eng_state_t;
endpackage : dma_step_pkg
